// ==== pkg/lfr_pkg.sv ====
// Package: addresses, field layouts, reset values and timing of the fault and fall-time block
package lfr_pkg;
    // Register byte addresses
    localparam logic [7:0] OFS_FALL_ONE = 8'h75; // Generator one fall time
    localparam logic [7:0] OFS_FALL_TWO = 8'h85; // Generator two fall time
    localparam logic [7:0] OFS_FALL_THREE = 8'h95; // Generator three fall time
    localparam logic [7:0] OFS_FALL_FOUR = 8'ha5; // Generator four fall time
    localparam logic [7:0] OFS_OPEN_STATUS = 8'hb0; // String open status
    localparam logic [7:0] OFS_SHORT_STATUS = 8'hb1; // String short status
    localparam logic [7:0] OFS_FAULT_ENABLE = 8'hb2; // Fault detection enables
    localparam logic [7:0] OFS_BOOST_CFG = 8'h1c; // Over-voltage threshold select
    // Field layout
    localparam int FALL_CODE_W = 3; // Fall-time code width
    localparam int STRING_COUNT = 7; // Two high-voltage plus five low-voltage
    localparam int BIT_OPEN_EN = 0; // Open detection enable bit
    localparam int BIT_SHORT_EN = 1; // Short detection enable bit
    // Reset values
    localparam logic [2:0] FALL_CODE_RESET = 3'h0; // 2048 us
    localparam logic [1:0] FAULT_EN_RESET = 2'h0; // Both detections off
    localparam logic [1:0] OVP_16V = 2'h0; // Threshold codes
    localparam logic [1:0] OVP_24V = 2'h1;
    localparam logic [1:0] OVP_32V = 2'h2;
    localparam logic [1:0] OVP_40V = 2'h3;
    localparam logic [1:0] OVP_RESET = OVP_16V; // Default threshold
    // Timing
    localparam int CLK_PERIOD_NS = 10; // 100 MHz core clock
    localparam int FALL_BASE_NS = 2048000; // Shortest fall time, 2048 us
    localparam int FALL_BASE_CYCLES = FALL_BASE_NS / CLK_PERIOD_NS; // 204800 cycles
    localparam int RAMP_STEPS = 256; // Brightness codes per full ramp
    localparam int LONG_SHIFT = 6; // Codes 1..7 span base times 2^(code+6)
    localparam int MULT_W = 14; // Holds 2^13
    // Serial slave
    localparam logic [6:0] SLAVE_ADDR_RESET = 7'h36; // Arbitrary default address
    // Serial slave states
    typedef enum logic [3:0] {
        LFR_IDLE = 4'h0,
        LFR_ADDR = 4'h1,
        LFR_ACK_ADDR = 4'h2,
        LFR_PTR = 4'h3,
        LFR_ACK_PTR = 4'h4,
        LFR_WDATA = 4'h5,
        LFR_ACK_W = 4'h6,
        LFR_RDATA = 4'h7,
        LFR_MACK = 4'h8
    } lfr_state_e;
endpackage

// ==== design/lfr_top.sv ====
// Fault readback, fall-time ramps, boost switch gating and serial register slave
`timescale 1ns/1ps
module lfr_top
    import lfr_pkg::*;
#(
    parameter int FALL_BASE = FALL_BASE_CYCLES, // Cycles of the shortest fall time
    parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_RESET // Arbitrary bus address
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hardware_enable_pin,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [3:0] ramp_fall_start,
    input wire logic [3:0][7:0] bank_brightness,
    input wire logic [3:0][7:0] ramp_low_level,
    output logic [3:0][7:0] ramp_level,
    output logic [3:0] ramp_falling,
    input wire logic [STRING_COUNT-1:0] open_detect_raw,
    input wire logic [STRING_COUNT-1:0] short_detect_raw,
    output logic open_detect_enable,
    output logic short_detect_enable,
    input wire logic switch_request,
    input wire logic ovp_reached,
    input wire logic ovp_below_hysteresis,
    input wire logic peak_current_limit,
    input wire logic period_start,
    output logic [1:0] over_voltage_threshold,
    output logic boost_power_switch
);
    localparam int STEP_CYCLES = FALL_BASE / RAMP_STEPS; // Cycles per ramp tick
    localparam int PRE_W = $clog2(STEP_CYCLES + 1); // Prescaler width
    localparam logic [PRE_W-1:0] STEP_LAST = PRE_W'(STEP_CYCLES - 1); // Prescaler wrap

    // Enable pin acts as a second asynchronous reset
    logic rst_n;
    assign rst_n = reset_n & hardware_enable_pin;

    // Serial slave state
    lfr_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next; // Bit count
    logic [7:0] shift_reg, shift_next; // Receive and transmit shifter
    logic [7:0] ptr_reg, ptr_next; // Register pointer
    logic drive_reg, drive_next; // Pull data line low
    logic scl_q, sda_q; // Previous line levels
    logic wr_en; // Register write strobe
    logic [7:0] rd_data, rd_next_data; // Read mux at pointer and pointer+1

    // Register file state
    logic [3:0][2:0] fall_reg, fall_next;
    logic [1:0] fault_en_reg, fault_en_next;
    logic [1:0] ovp_sel_reg, ovp_sel_next;
    logic [STRING_COUNT-1:0] open_reg, open_next;
    logic [STRING_COUNT-1:0] short_reg, short_next;

    // Boost switch state
    logic ovp_hold_reg, ovp_hold_next;
    logic icl_hold_reg, icl_hold_next;
    logic switch_reg, switch_next;

    // Read value of a register address
    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        unique case (a)
            OFS_FALL_ONE: rd_mux = {5'h00, fall_reg[0]};
            OFS_FALL_TWO: rd_mux = {5'h00, fall_reg[1]};
            OFS_FALL_THREE: rd_mux = {5'h00, fall_reg[2]};
            OFS_FALL_FOUR: rd_mux = {5'h00, fall_reg[3]};
            OFS_OPEN_STATUS: rd_mux = {1'b0, open_reg};
            OFS_SHORT_STATUS: rd_mux = {1'b0, short_reg};
            OFS_FAULT_ENABLE: rd_mux = {6'h00, fault_en_reg};
            OFS_BOOST_CFG: rd_mux = {6'h00, ovp_sel_reg};
            default: rd_mux = 8'h00; // Unmapped reads zero
        endcase
    endfunction

    assign rd_data = rd_mux(ptr_reg);
    assign rd_next_data = rd_mux(ptr_reg + 8'h01);

    // Line edge and condition detection
    logic scl_rise, scl_fall, start_cond, stop_cond;
    assign scl_rise = scl_in & ~scl_q;
    assign scl_fall = ~scl_in & scl_q;
    assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_cond = scl_in & scl_q & ~sda_q & sda_in;

    // Serial slave next state
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        drive_next = drive_reg;
        wr_en = 1'b0;
        if (start_cond) begin
            // Start or repeated start
            state_next = LFR_ADDR;
            cnt_next = 4'h0;
            drive_next = 1'b0;
        end else if (stop_cond) begin
            state_next = LFR_IDLE;
            drive_next = 1'b0;
        end else begin
            unique case (state_reg)
                LFR_IDLE: begin
                    drive_next = 1'b0;
                end
                LFR_ADDR, LFR_PTR, LFR_WDATA: begin
                    // Shift a byte in on rising clock
                    if (scl_rise && cnt_reg != 4'h8) begin
                        shift_next = {shift_reg[6:0], sda_in};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == 4'h8) begin
                        cnt_next = 4'h0;
                        drive_next = 1'b1;
                        if (state_reg == LFR_ADDR) begin
                            // Only our address is acknowledged
                            if (shift_reg[7:1] == SLAVE_ADDR) begin
                                state_next = LFR_ACK_ADDR;
                            end else begin
                                state_next = LFR_IDLE;
                                drive_next = 1'b0;
                            end
                        end else if (state_reg == LFR_PTR) begin
                            ptr_next = shift_reg;
                            state_next = LFR_ACK_PTR;
                        end else begin
                            wr_en = 1'b1;
                            state_next = LFR_ACK_W;
                        end
                    end
                end
                LFR_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (shift_reg[0]) begin
                            // Read: first bit goes out now
                            state_next = LFR_RDATA;
                            shift_next = rd_data;
                            drive_next = ~rd_data[7];
                        end else begin
                            state_next = LFR_PTR;
                            drive_next = 1'b0;
                        end
                    end
                end
                LFR_ACK_PTR: begin
                    if (scl_fall) begin
                        state_next = LFR_WDATA;
                        drive_next = 1'b0;
                    end
                end
                LFR_ACK_W: begin
                    if (scl_fall) begin
                        // Auto-increment after each written byte
                        ptr_next = ptr_reg + 8'h01;
                        state_next = LFR_WDATA;
                        drive_next = 1'b0;
                    end
                end
                LFR_RDATA: begin
                    // Shift out on falling clock
                    if (scl_fall) begin
                        if (cnt_reg == 4'h7) begin
                            cnt_next = 4'h0;
                            drive_next = 1'b0;
                            state_next = LFR_MACK;
                        end else begin
                            cnt_next = cnt_reg + 4'h1;
                            shift_next = {shift_reg[6:0], 1'b0};
                            drive_next = ~shift_reg[6];
                        end
                    end
                end
                LFR_MACK: begin
                    // Master acknowledge sampled, next byte or quit
                    if (scl_rise) begin
                        cnt_next = {3'h0, sda_in};
                    end else if (scl_fall) begin
                        if (cnt_reg == 4'h0) begin
                            ptr_next = ptr_reg + 8'h01;
                            shift_next = rd_next_data;
                            drive_next = ~rd_next_data[7];
                            state_next = LFR_RDATA;
                        end else begin
                            state_next = LFR_IDLE;
                        end
                        cnt_next = 4'h0;
                    end
                end
                default: begin
                    state_next = LFR_IDLE;
                    drive_next = 1'b0;
                end
            endcase
        end
    end

    // Serial slave registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= LFR_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            drive_reg <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            drive_reg <= drive_next;
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // Open-drain pin: low enable while pulling down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            sda_out <= 1'b0;
            sda_oe_n <= ~drive_next;
        end
    end

    // Register writes and fault status next values
    always_comb begin
        fall_next = fall_reg;
        fault_en_next = fault_en_reg;
        ovp_sel_next = ovp_sel_reg;
        if (wr_en) begin
            unique case (ptr_reg)
                OFS_FALL_ONE: fall_next[0] = shift_reg[2:0];
                OFS_FALL_TWO: fall_next[1] = shift_reg[2:0];
                OFS_FALL_THREE: fall_next[2] = shift_reg[2:0];
                OFS_FALL_FOUR: fall_next[3] = shift_reg[2:0];
                OFS_FAULT_ENABLE: fault_en_next = shift_reg[1:0];
                OFS_BOOST_CFG: ovp_sel_next = shift_reg[1:0];
                default: ; // Read-only or unmapped
            endcase
        end
        // Raw detector outputs gated by their enables
        open_next = open_detect_raw & {STRING_COUNT{fault_en_reg[BIT_OPEN_EN]}};
        short_next = short_detect_raw & {STRING_COUNT{fault_en_reg[BIT_SHORT_EN]}};
    end

    // Register file flip-flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_reg <= {4{FALL_CODE_RESET}};
            fault_en_reg <= FAULT_EN_RESET;
            ovp_sel_reg <= OVP_RESET;
            open_reg <= '0;
            short_reg <= '0;
        end else begin
            fall_reg <= fall_next;
            fault_en_reg <= fault_en_next;
            ovp_sel_reg <= ovp_sel_next;
            open_reg <= open_next;
            short_reg <= short_next;
        end
    end

    // Enable and threshold outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            open_detect_enable <= 1'b0;
            short_detect_enable <= 1'b0;
            over_voltage_threshold <= OVP_RESET;
        end else begin
            open_detect_enable <= fault_en_next[BIT_OPEN_EN];
            short_detect_enable <= fault_en_next[BIT_SHORT_EN];
            over_voltage_threshold <= ovp_sel_next;
        end
    end

    // Boost switch: trips latch off, trip wins over release
    always_comb begin
        ovp_hold_next = ovp_reached | (ovp_hold_reg & ~ovp_below_hysteresis);
        icl_hold_next = peak_current_limit | (icl_hold_reg & ~period_start);
        switch_next = switch_request & ~ovp_hold_next & ~icl_hold_next;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovp_hold_reg <= 1'b0;
            icl_hold_reg <= 1'b0;
            switch_reg <= 1'b0;
        end else begin
            ovp_hold_reg <= ovp_hold_next;
            icl_hold_reg <= icl_hold_next;
            switch_reg <= switch_next;
        end
    end
    assign boost_power_switch = switch_reg;

    // Shared ramp tick prescaler
    logic [PRE_W-1:0] pre_reg, pre_next;
    logic tick;
    always_comb begin
        tick = (pre_reg == STEP_LAST);
        pre_next = tick ? '0 : pre_reg + PRE_W'(1);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_next;
        end
    end

    // One fall ramp per pattern generator
    for (genvar g = 0; g < 4; g++) begin : g_ramp
        logic [7:0] level_reg, level_next;
        logic active_reg, active_next;
        logic [MULT_W-1:0] mcnt_reg, mcnt_next; // Ticks within one code step
        logic [MULT_W-1:0] mult; // Ticks per code step
        always_comb begin
            // Code 0 is base time, code k is base times 2^(k+6)
            mult = (fall_reg[g] == FALL_CODE_RESET) ? MULT_W'(1)
                : MULT_W'(1) << (MULT_W'(fall_reg[g]) + MULT_W'(LONG_SHIFT));
            level_next = level_reg;
            active_next = active_reg;
            mcnt_next = mcnt_reg;
            if (ramp_fall_start[g]) begin
                level_next = bank_brightness[g];
                active_next = 1'b1;
                mcnt_next = '0;
            end else if (active_reg && tick) begin
                if (mcnt_reg == mult - MULT_W'(1)) begin
                    mcnt_next = '0;
                    if (level_reg > ramp_low_level[g]) begin
                        level_next = level_reg - 8'h01;
                    end else begin
                        active_next = 1'b0;
                    end
                end else begin
                    mcnt_next = mcnt_reg + MULT_W'(1);
                end
            end
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                level_reg <= 8'h00;
                active_reg <= 1'b0;
                mcnt_reg <= '0;
            end else begin
                level_reg <= level_next;
                active_reg <= active_next;
                mcnt_reg <= mcnt_next;
            end
        end
        assign ramp_level[g] = level_reg;
        assign ramp_falling[g] = active_reg;
        a_ramp_load_high: assert property (@(posedge clk) disable iff (!rst_n)
            ramp_fall_start[g] |=> level_reg == $past(bank_brightness[g]) && active_reg)
            else $error("Ramp did not start from bank brightness");
    end

    // Checks
    a_ovp_switch_off: assert property (@(posedge clk) disable iff (!rst_n)
        ovp_reached |=> !boost_power_switch [*1] ##0 ovp_hold_reg)
        else $error("Switch on after over-voltage");
    a_ovp_hold_off: assert property (@(posedge clk) disable iff (!rst_n)
        ovp_hold_reg && !ovp_below_hysteresis |=> !boost_power_switch)
        else $error("Switch released above hysteresis");
    a_icl_switch_off: assert property (@(posedge clk) disable iff (!rst_n)
        peak_current_limit ##1 !period_start |=> !boost_power_switch)
        else $error("Switch on within limited period");
    a_icl_release: assert property (@(posedge clk) disable iff (!rst_n)
        icl_hold_reg && period_start && switch_request && !peak_current_limit
        && !ovp_hold_next |=> boost_power_switch)
        else $error("Switch not restored at new period");
    a_open_gate_off: assert property (@(posedge clk) disable iff (!rst_n)
        !fault_en_reg[BIT_OPEN_EN] |=> open_reg == '0)
        else $error("Open status set while disabled");
    a_short_gate_off: assert property (@(posedge clk) disable iff (!rst_n)
        !fault_en_reg[BIT_SHORT_EN] |=> short_reg == '0)
        else $error("Short status set while disabled");
    a_open_report: assert property (@(posedge clk) disable iff (!rst_n)
        fault_en_reg[BIT_OPEN_EN] |=> open_reg == $past(open_detect_raw))
        else $error("Open status does not follow detector");
    a_fall_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && ptr_reg == OFS_FALL_THREE |=> fall_reg[2] == $past(shift_reg[2:0]))
        else $error("Fall-time write lost");
    a_ovp_cfg_out: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && ptr_reg == OFS_BOOST_CFG |=> over_voltage_threshold == $past(shift_reg[1:0]))
        else $error("Threshold output not updated");
endmodule // lfr_top

// ==== tb/lfr_host.sv ====
// Host model: serial bus master that writes and reads device registers
`timescale 1ns/1ps
module lfr_host (
    input wire logic clk,
    output logic scl,
    output logic sda_drv,
    input wire logic sda_line
);
    // Both lines released (pulled up) while idle
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Wait whole core clock cycles
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One bit: data moves while clock low, sampled at end of clock high
    task automatic bit_io(input logic b, output logic r);
        sda_drv <= b;
        tick(4);
        scl <= 1'b1;
        tick(8);
        r = sda_line;
        scl <= 1'b0;
        tick(4);
    endtask
    // Start or repeated start: data falls while clock high
    task automatic start();
        sda_drv <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(8);
        sda_drv <= 1'b0;
        tick(8);
        scl <= 1'b0;
        tick(4);
    endtask
    // Stop: data rises while clock high
    task automatic stop();
        sda_drv <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(8);
        sda_drv <= 1'b1;
        tick(8);
    endtask
    // Byte most significant bit first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic m_ack, output logic [7:0] rx,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(m_ack, ack);
    endtask
    // Write one register; ok only when every byte was acknowledged
    task automatic reg_write(input logic [6:0] dev, input logic [7:0] ptr,
                             input logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, a0);
        xfer(ptr, 1'b1, rx, a1);
        xfer(d, 1'b1, rx, a2);
        stop();
        ok = !(a0 | a1 | a2);
    endtask
    // Read one register through a repeated start, last byte not acknowledged
    task automatic reg_read(input logic [6:0] dev, input logic [7:0] ptr,
                            output logic [7:0] d);
        logic [7:0] rx;
        logic a;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, a);
        xfer(ptr, 1'b1, rx, a);
        start();
        xfer({dev, 1'b1}, 1'b1, rx, a);
        xfer(8'hff, 1'b1, d, a);
        stop();
    endtask
endmodule // lfr_host

// ==== tb/lfr_top_test.sv ====
// Testbench: registers, fault readback, boost gating and fall ramps
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("FAIL %0t got %h exp %h", $time, a, e); end end
module lfr_top_test;
    import lfr_pkg::*;
    localparam int FB = 2560; // Short fall base, step of 10 cycles
    localparam logic [6:0] DEV = 7'h36; // Arbitrary bus address
    localparam logic [7:0] FOFS [4] = '{OFS_FALL_ONE, OFS_FALL_TWO, OFS_FALL_THREE, OFS_FALL_FOUR};
    logic clk, reset_n, hardware_enable_pin, scl, sda_drv, sda_out, sda_oe_n;
    logic switch_request, ovp_reached, ovp_below_hysteresis, peak_current_limit, period_start;
    logic open_detect_enable, short_detect_enable, boost_power_switch;
    logic [3:0] ramp_fall_start, ramp_falling;
    logic [3:0][7:0] bank_brightness, ramp_low_level, ramp_level;
    logic [STRING_COUNT-1:0] open_detect_raw, short_detect_raw;
    logic [1:0] over_voltage_threshold;
    wire logic sda_line; // Resolved open-drain data wire
    int bad_count = 0;
    int num_checks = 0;
    assign sda_line = sda_drv & (sda_oe_n | sda_out);
    lfr_top #(.FALL_BASE(FB), .SLAVE_ADDR(DEV)) lfr_top_i (.clk(clk), .reset_n(reset_n),
        .hardware_enable_pin(hardware_enable_pin), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .ramp_fall_start(ramp_fall_start),
        .bank_brightness(bank_brightness), .ramp_low_level(ramp_low_level),
        .ramp_level(ramp_level), .ramp_falling(ramp_falling), .open_detect_raw(open_detect_raw),
        .short_detect_raw(short_detect_raw), .open_detect_enable(open_detect_enable),
        .short_detect_enable(short_detect_enable), .switch_request(switch_request),
        .ovp_reached(ovp_reached), .ovp_below_hysteresis(ovp_below_hysteresis),
        .peak_current_limit(peak_current_limit), .period_start(period_start),
        .over_voltage_threshold(over_voltage_threshold), .boost_power_switch(boost_power_switch));
    lfr_host lfr_host_i (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
    // Write through the host; the device must acknowledge
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic ok;
        lfr_host_i.reg_write(DEV, p, d, ok);
        `CHK(ok, 1'b1)
    endtask
    // Read through the host and compare
    task automatic rd(input logic [7:0] p, input logic [7:0] exp);
        logic [7:0] d;
        lfr_host_i.reg_read(DEV, p, d);
        `CHK(d, exp)
    endtask
    // Wait edges, then look at settled outputs
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // Reset values after power-up
    task automatic t_reset_values();
        for (int i = 0; i < 4; i++) rd(FOFS[i], 8'h00);
        rd(OFS_FAULT_ENABLE, 8'h00);
        `CHK(over_voltage_threshold, OVP_16V)
    endtask
    // Each fall code once: generator i takes code i+4 then code i, last pass leaves codes 0..3
    task automatic t_fall_codes();
        logic [7:0] c;
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 4; i++) begin
                c = 8'(j ? i : i + 4);
                wr(FOFS[i], c);
                rd(FOFS[i], c);
            end
        end
    endtask
    // Open and short readback gated by their own enables
    task automatic t_faults();
        @(posedge clk);
        open_detect_raw <= 7'h55;
        short_detect_raw <= 7'h2a;
        rd(OFS_OPEN_STATUS, 8'h00);
        rd(OFS_SHORT_STATUS, 8'h00);
        wr(OFS_FAULT_ENABLE, 8'h01);
        rd(OFS_OPEN_STATUS, 8'h55);
        rd(OFS_SHORT_STATUS, 8'h00);
        `CHK({short_detect_enable, open_detect_enable}, 2'b01)
        wr(OFS_FAULT_ENABLE, 8'h02);
        rd(OFS_OPEN_STATUS, 8'h00);
        rd(OFS_SHORT_STATUS, 8'h2a);
        rd(8'h10, 8'h00);
    endtask
    // Over-voltage and peak-current holds on the power switch
    task automatic t_boost();
        @(posedge clk);
        switch_request <= 1'b1;
        settle(1);
        `CHK(boost_power_switch, 1'b1)
        @(posedge clk);
        ovp_reached <= 1'b1;
        @(posedge clk);
        ovp_reached <= 1'b0;
        settle(5);
        `CHK(boost_power_switch, 1'b0)
        @(posedge clk);
        ovp_below_hysteresis <= 1'b1;
        settle(3);
        `CHK(boost_power_switch, 1'b1)
        @(posedge clk);
        ovp_below_hysteresis <= 1'b0;
        @(posedge clk);
        peak_current_limit <= 1'b1;
        @(posedge clk);
        peak_current_limit <= 1'b0;
        settle(5);
        `CHK(boost_power_switch, 1'b0)
        @(posedge clk);
        period_start <= 1'b1;
        @(posedge clk);
        period_start <= 1'b0;
        settle(2);
        `CHK(boost_power_switch, 1'b1)
    endtask
    // All four load bank level; code 0 on one (4 steps), code 1 on two (1 step)
    task automatic t_ramp();
        @(posedge clk);
        bank_brightness[0] <= 8'h20;
        bank_brightness[1] <= 8'h1d;
        bank_brightness[2] <= 8'h40;
        bank_brightness[3] <= 8'h80;
        ramp_low_level[0] <= 8'h1c;
        ramp_low_level[1] <= 8'h1c;
        @(posedge clk);
        ramp_fall_start <= 4'b1111;
        @(posedge clk);
        ramp_fall_start <= 4'b0000;
        @(negedge clk);
        `CHK({ramp_level, ramp_falling}, {8'h80, 8'h40, 8'h1d, 8'h20, 4'hf})
        settle(20);
        `CHK(ramp_falling[0], 1'b1)
        settle(40);
        `CHK({ramp_level[0], ramp_falling[0]}, 9'h038)
        settle(580);
        `CHK(ramp_falling[1], 1'b1)
        settle(700);
        `CHK({ramp_level[1], ramp_falling[1]}, 9'h039)
        settle(1260);
        `CHK({ramp_level[1], ramp_falling[1]}, 9'h038)
    endtask
    // Threshold codes, enable-pin reset back to 16V, then reprogram
    task automatic t_threshold();
        for (int k = 0; k < 4; k++) begin
            wr(OFS_BOOST_CFG, 8'(k));
            settle(1);
            `CHK(over_voltage_threshold, 2'(k))
        end
        @(posedge clk);
        hardware_enable_pin <= 1'b0;
        repeat (2) @(posedge clk);
        hardware_enable_pin <= 1'b1;
        settle(1);
        `CHK(over_voltage_threshold, OVP_16V)
        rd(FOFS[1], 8'h00);
        wr(OFS_BOOST_CFG, {6'h00, OVP_40V});
        settle(1);
        `CHK(over_voltage_threshold, OVP_40V)
    endtask
    // Counts, verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Core clock, 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard, well beyond the expected run
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        stop_test();
    end
    // Main sequence
    initial begin
        {reset_n, switch_request, ovp_reached, ovp_below_hysteresis} = 4'h0;
        {peak_current_limit, period_start, ramp_fall_start} = 6'h00;
        hardware_enable_pin = 1'b1;
        {bank_brightness, ramp_low_level} = '0;
        {open_detect_raw, short_detect_raw} = '0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset_values();
        t_fall_codes();
        t_faults();
        t_boost();
        t_ramp();
        t_threshold();
        stop_test();
    end
endmodule // lfr_top_test
